/* rtl/hw_config.sv */
// Hardware configuration register bank, low fields plus drive boost,
// with soft reset sequencer, EEPROM time-out and receive padding.
// Assumes an APB master on pclk; all datapath inputs share pclk
// except the PHY choice strap, which is synchronised here.
//
// Functional notes
// - Receive packets start after zero to three zero pad bytes.
// - Loss of sync stalls Bulk Out unless stall-disable is set.
// - Internal PHY plus visibility bit drives MII pins as outputs.
// - Visibility bit ignored when an external PHY is used.
// - Visibility bit overrides GPIO setup for the MII pins.
// - Drop bit discards errored received frames, else keeps them.
// - Packing bit allows several frames per USB transmit packet.
// - USB receive path always accepts several frames per packet.
// - EEPROM time-out after 30 ms, or 1.28 us when selected.
// - Lite reset bit starts lite reset, self-clears when done.
// - Lite reset spares USB core, EEPROM load and USB connection.
// - PHY choice bit reads 0 internal, 1 external PHY.
// - PHY choice bit reads 0 after presetn, takes the PHY choice pin on a full reset.
// - Burst enable bit applies the burst limit value to transmit.
// - Full reset bit resets the device and any external PHY.
// - Full reset reloads EEPROM, disconnects USB PHY, reconnects.
// - Drive boost follows EEPROM image, restored on USB/lite reset.
// - Detach status bit reads set after a detach-until-link event.
`timescale 1ns/1ns

module hw_config
	import hw_config_pkg::*;
#(
	parameter int EE_LONG_CYCLES = EE_TIMEOUT_LONG_CYCLES
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Straps and system events
	input  wire logic        phy_choice_pin,
	input  wire logic        usb_bus_reset,
	input  wire logic        detach_event,
	input  wire logic        rx_datapath_enable,
	// EEPROM controller
	input  wire logic        eeprom_present,
	input  wire logic [1:0]  eeprom_boost,
	input  wire logic        eeprom_load_done,
	input  wire logic        eeprom_busy,
	input  wire logic        eeprom_response,
	output logic             eeprom_timeout,
	output logic             eeprom_reload,
	// Transmit side
	input  wire logic        tx_loss_of_sync,
	input  wire logic        bulk_out_stall_clear,
	input  wire logic [15:0] burst_limit_value,
	output logic             bulk_out_stall,
	output logic             multi_frame_packing,
	output logic             usb_rx_multi_frame,
	output logic [15:0]      tx_burst_limit,
	// Receive byte stream in and padded stream out
	input  wire logic        rx_in_valid,
	input  wire logic [7:0]  rx_in_data,
	input  wire logic        rx_in_sop,
	input  wire logic        rx_in_last,
	input  wire logic        rx_in_error,
	output logic             rx_in_ready,
	output logic             rx_out_valid,
	output logic [7:0]       rx_out_data,
	output logic             rx_out_sop,
	output logic             rx_out_last,
	output logic             rx_frame_discard,
	// Pin and reset control
	output logic             mii_pins_drive,
	output logic             gpio_override,
	output logic [1:0]       hs_drive_boost,
	output logic             datapath_reset,
	output logic             usb_core_reset,
	output logic             usb_phy_disconnect,
	output logic             ext_phy_reset
);

	////////////////////////////////////////////////////////////////////
	// Register state

	logic [1:0]      rx_start_shift_q;
	logic            bulk_out_stall_disable_q;
	logic            mii_visibility_enable_q;
	logic            drop_errored_frames_q;
	logic            multi_frame_packing_q;
	logic            eeprom_timeout_select_q;
	logic            burst_limit_enable_q;
	logic [1:0]      boost_q;
	logic [1:0]      boost_image_q;
	logic            detach_sts_q;
	logic            phy_ext_q;
	logic            strap_taken_q;
	logic            sync1_q;
	logic            sync2_q;
	seq_state_t      state_q;
	seq_state_t      state_d;
	logic [5:0]      seq_cnt_q;
	logic [5:0]      seq_cnt_d;
	logic [EE_CNT_W-1:0] ee_cnt_q;
	logic            ee_fired_q;

	////////////////////////////////////////////////////////////////////
	// APB decode

	wire        access   = psel & penable;
	wire        commit   = access & pready;
	wire        hit_cfg  = paddr == HW_CFG_OFF;
	wire        hit_sts  = paddr == HW_STATUS_OFF;
	wire        hit_any  = hit_cfg | hit_sts;
	wire        wr_cfg   = commit & pwrite & hit_cfg;
	wire        wr_sts   = commit & pwrite & hit_sts;
	wire        seq_idle = state_q == SEQ_IDLE;
	wire        full_go  = wr_cfg & seq_idle & pwdata[FULL_RST_BIT];
	wire        lite_go  = wr_cfg & seq_idle & ~pwdata[FULL_RST_BIT]
		& pwdata[LITE_RST_BIT];
	wire        full_start = state_d == SEQ_HOLD && state_q != SEQ_HOLD;
	wire        lite_start = state_d == SEQ_LITE && state_q != SEQ_LITE;

	// Read view of the configuration register
	wire [31:0] cfg_view = {
		17'h00000,
		boost_q,
		2'h0,
		rx_start_shift_q,
		bulk_out_stall_disable_q,
		mii_visibility_enable_q,
		drop_errored_frames_q,
		multi_frame_packing_q,
		eeprom_timeout_select_q,
		state_q == SEQ_LITE,
		phy_ext_q,
		burst_limit_enable_q,
		state_q == SEQ_HOLD || state_q == SEQ_LOAD
	};
	wire [31:0] sts_view = {31'h00000000, detach_sts_q};
	wire [31:0] rd_mux   = hit_cfg ? cfg_view :
		hit_sts ? sts_view : 32'h00000000;

	// One wait state, then answer with data or error
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else
		begin
			pready  <= access & ~pready;
			pslverr <= access & ~pready & ~hit_any;
			prdata  <= (access & ~pready & ~pwrite) ? rd_mux : 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////
	// PHY choice strap: synchronise, then catch after reset and again on each full reset

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end
		else
		begin
			sync1_q <= phy_choice_pin;
			sync2_q <= sync1_q;
		end
	end

	// Caught one cycle after reset release, before sync2_q holds the pin, and again by a full soft reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strap_taken_q <= 1'b0;
			phy_ext_q     <= 1'b0;
		end
		else if (full_start)
			strap_taken_q <= 1'b0;
		else if (!strap_taken_q)
		begin
			strap_taken_q <= 1'b1;
			phy_ext_q     <= sync2_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Writable fields; a full reset returns them to defaults

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_start_shift_q         <= SHIFT_RST;
			bulk_out_stall_disable_q <= FLAG_RST;
			mii_visibility_enable_q  <= FLAG_RST;
			drop_errored_frames_q    <= FLAG_RST;
			multi_frame_packing_q    <= FLAG_RST;
			eeprom_timeout_select_q  <= FLAG_RST;
			burst_limit_enable_q     <= FLAG_RST;
		end
		else if (full_start)
		begin
			rx_start_shift_q         <= SHIFT_RST;
			bulk_out_stall_disable_q <= FLAG_RST;
			mii_visibility_enable_q  <= FLAG_RST;
			drop_errored_frames_q    <= FLAG_RST;
			multi_frame_packing_q    <= FLAG_RST;
			eeprom_timeout_select_q  <= FLAG_RST;
			burst_limit_enable_q     <= FLAG_RST;
		end
		else if (wr_cfg)
		begin
			if (!rx_datapath_enable)
				rx_start_shift_q <= pwdata[SHIFT_HI:SHIFT_LO];
			bulk_out_stall_disable_q <= pwdata[STALL_DIS_BIT];
			mii_visibility_enable_q  <= pwdata[MII_VIS_BIT];
			drop_errored_frames_q    <= pwdata[DROP_ERR_BIT];
			multi_frame_packing_q    <= pwdata[MULTI_PACK_BIT];
			eeprom_timeout_select_q  <= pwdata[EE_TO_SEL_BIT];
			burst_limit_enable_q     <= pwdata[BURST_EN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Drive boost and its EEPROM image

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			boost_q       <= BOOST_RST;
			boost_image_q <= BOOST_RST;
		end
		else if (eeprom_load_done)
		begin
			boost_image_q <= eeprom_present ? eeprom_boost : BOOST_RST;
			boost_q       <= eeprom_present ? eeprom_boost : BOOST_RST;
		end
		else if (full_start)
			boost_q <= BOOST_RST;
		else if (usb_bus_reset || lite_start)
			boost_q <= boost_image_q;
		else if (wr_cfg)
			boost_q <= pwdata[BOOST_HI:BOOST_LO];
	end

	////////////////////////////////////////////////////////////////////
	// Detach status: event sets, write one clears, set wins

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			detach_sts_q <= 1'b0;
		else if (detach_event)
			detach_sts_q <= 1'b1;
		else if (wr_sts && pwdata[DETACH_STS_BIT])
			detach_sts_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// Soft reset sequencer

	always_comb
	begin
		state_d   = state_q;
		seq_cnt_d = seq_cnt_q;
		unique case (state_q)
			SEQ_IDLE:
			begin
				if (full_go)
				begin
					state_d   = SEQ_HOLD;
					seq_cnt_d = FULL_RST_CYCLES;
				end
				else if (lite_go)
				begin
					state_d   = SEQ_LITE;
					seq_cnt_d = LITE_RST_CYCLES;
				end
			end
			SEQ_LITE:
			begin
				seq_cnt_d = seq_cnt_q - 6'h01;
				if (seq_cnt_q == 6'h01)
					state_d = SEQ_IDLE;
			end
			SEQ_HOLD:
			begin
				seq_cnt_d = seq_cnt_q - 6'h01;
				if (seq_cnt_q == 6'h01)
					state_d = SEQ_LOAD;
			end
			SEQ_LOAD:
			begin
				if (eeprom_load_done)
					state_d = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q   <= SEQ_IDLE;
			seq_cnt_q <= 6'h00;
		end
		else
		begin
			state_q   <= state_d;
			seq_cnt_q <= seq_cnt_d;
		end
	end

	// Reset outputs follow the next state so they align with it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			datapath_reset     <= 1'b0;
			usb_core_reset     <= 1'b0;
			usb_phy_disconnect <= 1'b0;
			ext_phy_reset      <= 1'b0;
			eeprom_reload      <= 1'b0;
		end
		else
		begin
			datapath_reset     <= state_d != SEQ_IDLE;
			usb_core_reset     <= state_d == SEQ_HOLD;
			usb_phy_disconnect <= state_d == SEQ_HOLD
				|| state_d == SEQ_LOAD;
			ext_phy_reset      <= state_d == SEQ_HOLD && phy_ext_q;
			eeprom_reload      <= state_d == SEQ_LOAD
				&& state_q == SEQ_HOLD;
		end
	end

	////////////////////////////////////////////////////////////////////
	// EEPROM response time-out

	wire [EE_CNT_W-1:0] ee_limit = eeprom_timeout_select_q
		? EE_CNT_W'(EE_TIMEOUT_SHORT_CYCLES - 1)
		: EE_CNT_W'(EE_LONG_CYCLES - 1);
	wire ee_hit = eeprom_busy & ~eeprom_response & ~ee_fired_q
		& (ee_cnt_q == ee_limit);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ee_cnt_q       <= '0;
			ee_fired_q     <= 1'b0;
			eeprom_timeout <= 1'b0;
		end
		else
		begin
			eeprom_timeout <= ee_hit;
			if (!eeprom_busy || eeprom_response)
			begin
				ee_cnt_q   <= '0;
				ee_fired_q <= 1'b0;
			end
			else if (ee_hit)
				ee_fired_q <= 1'b1;
			else if (!ee_fired_q)
				ee_cnt_q <= ee_cnt_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Transmit controls and pin steering

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bulk_out_stall      <= 1'b0;
			multi_frame_packing <= 1'b0;
			usb_rx_multi_frame  <= 1'b0;
			tx_burst_limit      <= 16'hffff;
			mii_pins_drive      <= 1'b0;
			gpio_override       <= 1'b0;
			hs_drive_boost      <= BOOST_RST;
		end
		else
		begin
			if (tx_loss_of_sync && !bulk_out_stall_disable_q)
				bulk_out_stall <= 1'b1;
			else if (bulk_out_stall_clear || state_q != SEQ_IDLE)
				bulk_out_stall <= 1'b0;
			multi_frame_packing <= multi_frame_packing_q;
			usb_rx_multi_frame  <= 1'b1;
			tx_burst_limit      <= burst_limit_enable_q
				? burst_limit_value : 16'hffff;
			mii_pins_drive <= mii_visibility_enable_q
				& ~phy_ext_q;
			gpio_override  <= mii_visibility_enable_q
				& ~phy_ext_q;
			hs_drive_boost <= boost_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Receive start shift: zero pad bytes ahead of each packet

	logic [1:0] pad_left_q;
	logic [1:0] pad_left_d;
	logic [7:0] held_data_q;
	logic       held_last_q;
	logic       held_v_q;
	logic       held_v_d;
	logic       out_v_d;
	logic [7:0] out_data_d;
	logic       out_sop_d;
	logic       out_last_d;

	wire rx_take = rx_in_valid & rx_in_ready;

	always_comb
	begin
		pad_left_d = pad_left_q;
		held_v_d   = held_v_q;
		out_v_d    = 1'b0;
		out_data_d = 8'h00;
		out_sop_d  = 1'b0;
		out_last_d = 1'b0;
		if (pad_left_q != 2'h0)
		begin
			out_v_d    = 1'b1;
			pad_left_d = pad_left_q - 2'h1;
		end
		else if (held_v_q)
		begin
			out_v_d    = 1'b1;
			out_data_d = held_data_q;
			out_last_d = held_last_q;
			held_v_d   = 1'b0;
		end
		else if (rx_take)
		begin
			out_v_d   = 1'b1;
			out_sop_d = rx_in_sop;
			if (rx_in_sop && rx_start_shift_q != 2'h0)
			begin
				held_v_d   = 1'b1;
				pad_left_d = rx_start_shift_q - 2'h1;
			end
			else
			begin
				out_data_d = rx_in_data;
				out_last_d = rx_in_last;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pad_left_q       <= 2'h0;
			held_v_q         <= 1'b0;
			held_data_q      <= 8'h00;
			held_last_q      <= 1'b0;
			rx_in_ready      <= 1'b0;
			rx_out_valid     <= 1'b0;
			rx_out_data      <= 8'h00;
			rx_out_sop       <= 1'b0;
			rx_out_last      <= 1'b0;
			rx_frame_discard <= 1'b0;
		end
		else
		begin
			pad_left_q   <= pad_left_d;
			held_v_q     <= held_v_d;
			rx_in_ready  <= pad_left_d == 2'h0 && !held_v_d;
			rx_out_valid <= out_v_d;
			rx_out_data  <= out_data_d;
			rx_out_sop   <= out_sop_d;
			rx_out_last  <= out_last_d;
			if (rx_take)
			begin
				held_data_q <= rx_in_data;
				held_last_q <= rx_in_last;
			end
			rx_frame_discard <= rx_take & rx_in_last & rx_in_error
				& drop_errored_frames_q;
		end
	end

endmodule : hw_config

/* rtl/hw_config_pkg.sv */
// Constants for the hardware configuration register bank:
// offsets, field positions, reset values and timing counts.
// Assumes a 100 MHz APB clock and 32-bit APB data.
package hw_config_pkg;

	// Clock
	localparam int CLK_PERIOD_NS = 10;

	// Register byte offsets
	localparam logic [11:0] HW_CFG_OFF    = 12'h000;
	localparam logic [11:0] HW_STATUS_OFF = 12'h004;

	// Field positions in hardware_configuration
	localparam int BOOST_HI       = 14;
	localparam int BOOST_LO       = 13;
	localparam int SHIFT_HI       = 10;
	localparam int SHIFT_LO       = 9;
	localparam int STALL_DIS_BIT  = 8;
	localparam int MII_VIS_BIT    = 7;
	localparam int DROP_ERR_BIT   = 6;
	localparam int MULTI_PACK_BIT = 5;
	localparam int EE_TO_SEL_BIT  = 4;
	localparam int LITE_RST_BIT   = 3;
	localparam int PHY_EXT_BIT    = 2;
	localparam int BURST_EN_BIT   = 1;
	localparam int FULL_RST_BIT   = 0;

	// Field positions in the status register
	localparam int DETACH_STS_BIT = 0;

	// Reset values
	localparam logic [1:0] SHIFT_RST = 2'h0;
	localparam logic [1:0] BOOST_RST = 2'h0;
	localparam logic       FLAG_RST  = 1'b0;

	// EEPROM time-out, as printed, and derived cycle counts
	localparam int  EE_TIMEOUT_LONG_MS  = 30;
	localparam real EE_TIMEOUT_SHORT_US = 1.28;
	localparam int  EE_TIMEOUT_LONG_CYCLES =
		EE_TIMEOUT_LONG_MS * 1000000 / CLK_PERIOD_NS;
	localparam int  EE_TIMEOUT_SHORT_CYCLES =
		int'(EE_TIMEOUT_SHORT_US * 1000.0) / CLK_PERIOD_NS;
	localparam int  EE_CNT_W = 22;

	// Soft reset sequence lengths in cycles
	localparam logic [5:0] LITE_RST_CYCLES = 6'h10;
	localparam logic [5:0] FULL_RST_CYCLES = 6'h20;

	// Reset sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_LITE = 2'b01,
		SEQ_HOLD = 2'b10,
		SEQ_LOAD = 2'b11
	} seq_state_t;

endpackage : hw_config_pkg

/* bench/hw_config_asserts.sv */
// Port checker for hw_config: APB pacing, soft reset sequences, datapath.
// Assumes it is bound to hw_config and sees only its ports.
`timescale 1ns/1ns

module hw_config_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        tx_loss_of_sync,
	input wire logic        bulk_out_stall,
	input wire logic        usb_rx_multi_frame,
	input wire logic [15:0] tx_burst_limit,
	input wire logic [15:0] burst_limit_value,
	input wire logic        mii_pins_drive,
	input wire logic        gpio_override,
	input wire logic        datapath_reset,
	input wire logic        usb_core_reset,
	input wire logic        usb_phy_disconnect,
	input wire logic        ext_phy_reset,
	input wire logic        eeprom_reload,
	input wire logic        eeprom_load_done,
	input wire logic        eeprom_busy,
	input wire logic        eeprom_timeout,
	input wire logic        rx_in_valid,
	input wire logic        rx_in_ready,
	input wire logic        rx_in_last,
	input wire logic        rx_in_error,
	input wire logic        rx_out_valid,
	input wire logic [7:0]  rx_out_data,
	input wire logic        rx_frame_discard
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////
	// One wait state on every access
	a_apb_wait: assert property ($rose(penable) && psel |->
		!pready ##1 pready)
		else $error("pready not in second access cycle");
	// Burst cap either the outside value or unlimited
	a_burst_cap: assert property (tx_burst_limit == 16'hffff ||
		tx_burst_limit == $past(burst_limit_value))
		else $error("burst limit neither cap nor open");
	a_stall_cause: assert property ($rose(bulk_out_stall) |->
		$past(tx_loss_of_sync))
		else $error("stall without loss of sync");
	a_mii_gpio: assert property (mii_pins_drive ==
		gpio_override)
		else $error("pin drive and gpio override differ");
	a_rx_multi: assert property ($past(presetn) |->
		usb_rx_multi_frame)
		else $error("receive multi frame not set");
	// Lite reset: sixteen cycles, core and connection untouched for the first eight
	a_lite_len: assert property (
		$rose(datapath_reset) && !usb_core_reset |->
		datapath_reset[*8] ##1 datapath_reset[*8] ##1 !datapath_reset)
		else $error("lite reset length wrong");
	a_lite_spare: assert property (
		$rose(datapath_reset) && !usb_core_reset |->
		(!usb_phy_disconnect && !eeprom_reload && !usb_core_reset)[*8])
		else $error("lite reset touched core or connection");
	// Full reset: hold, reload, stay disconnected until load ends
	a_full_seq: assert property ($rose(usb_core_reset) |->
		(usb_phy_disconnect && datapath_reset) ##31 usb_core_reset ##1
		(eeprom_reload && !usb_core_reset && usb_phy_disconnect))
		else $error("full reset sequence wrong");
	a_full_end: assert property (eeprom_load_done &&
		usb_phy_disconnect && !usb_core_reset && !eeprom_reload |=>
		!usb_phy_disconnect && !datapath_reset)
		else $error("no reconnect after load");
	a_ext_reset: assert property (ext_phy_reset |->
		usb_core_reset)
		else $error("external phy reset outside full reset");
	a_ee_pulse: assert property (eeprom_timeout |->
		$past(eeprom_busy) ##1 !eeprom_timeout)
		else $error("eeprom time-out pulse wrong");
	a_drop_cause: assert property (rx_frame_discard |->
		$past(rx_in_valid && rx_in_ready && rx_in_last && rx_in_error))
		else $error("discard without errored last byte");
	a_pad_zero: assert property (rx_out_valid && !rx_in_ready |->
		rx_out_data == 8'h00)
		else $error("pad byte not zero");

	// Main scenarios reached
	c_full: cover property ($fell(usb_core_reset));
	c_lite: cover property ($rose(datapath_reset) && !usb_core_reset);
	c_drop: cover property (rx_frame_discard);
	c_ee: cover property (eeprom_timeout);
endmodule : hw_config_asserts

bind hw_config hw_config_asserts u_chk (.*);

/* bench/testbench.sv */
// Self-checking bench for hw_config: fields, receive padding, stall,
// soft resets, EEPROM time-out. Assumes the checker is bound to it.
`timescale 1ns/1ns

module testbench
	import hw_config_pkg::*;
;
	localparam int EE_LONG = 200;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        phy_choice_pin, usb_bus_reset, detach_event, err;
	logic        rx_datapath_enable, eeprom_present, eeprom_load_done;
	logic        eeprom_busy, eeprom_response, eeprom_timeout, eeprom_reload;
	logic        tx_loss_of_sync, bulk_out_stall_clear, bulk_out_stall;
	logic        multi_frame_packing, usb_rx_multi_frame, rx_in_valid;
	logic        rx_in_sop, rx_in_last, rx_in_error, rx_in_ready;
	logic        rx_out_valid, rx_out_sop, rx_out_last, rx_frame_discard;
	logic        mii_pins_drive, gpio_override, datapath_reset;
	logic        usb_core_reset, usb_phy_disconnect, ext_phy_reset;
	logic [1:0]  eeprom_boost, hs_drive_boost;
	logic [15:0] burst_limit_value, tx_burst_limit;
	logic [7:0]  rx_in_data, rx_out_data;
	int          n_mismatch, tests_run;

	hw_config #(.EE_LONG_CYCLES(EE_LONG)) dut (.*);

	// Clock
	always #5 pclk = ~pclk;

	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge pclk);
	endtask : step

	// Bounded wait for a level, n counts edges
	task automatic wait_lvl(ref logic s, input logic v, input int lim,
		output int n);
		n = 0;
		while (s !== v && n < lim)
		begin
			@(posedge pclk);
			n++;
		end
	endtask : wait_lvl

	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		chk("apb_wait", 32'h2, 32'(n));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input string nm, input logic [11:0] a,
		input logic [31:0] m, e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd & m);
	endtask : rdc

	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////
	task automatic t_fields;
		step(4);
		rdc("cfg_rst", HW_CFG_OFF, 32'h67ff, 32'h0);
		chk("burst_rst", 16'hffff, tx_burst_limit);
		chk("rx_multi", 1, usb_rx_multi_frame);
		wr(HW_CFG_OFF, 32'h7f2);
		rdc("cfg_rw", HW_CFG_OFF, 32'h67ff, 32'h7f2);
		chk("packing", 1, multi_frame_packing);
		chk("mii_drive", 1, mii_pins_drive);
		chk("gpio_ovr", 1, gpio_override);
		chk("burst_cap", 16'h0123, tx_burst_limit);
		rx_datapath_enable <= 1'b1;
		wr(HW_CFG_OFF, 32'h1f2);
		rdc("shift_lock", HW_CFG_OFF, 32'h600, 32'h600);
		rx_datapath_enable <= 1'b0;
		wr(HW_CFG_OFF, 32'h0);
		step(2);
		chk("packing_off", 0, multi_frame_packing);
		chk("mii_off", 0, mii_pins_drive);
		chk("burst_open", 16'hffff, tx_burst_limit);
	endtask : t_fields

	// One-byte errored frame through the pad logic
	task automatic t_rx(input logic [1:0] n, input logic drop);
		int disc;
		logic [7:0] q[$];
		logic [1:0] f[$];
		disc = 0;
		wr(HW_CFG_OFF, {21'h0, n, 2'b00, drop, 6'h0});
		@(posedge pclk);
		rx_in_valid <= 1'b1;
		rx_in_sop <= 1'b1;
		rx_in_last <= 1'b1;
		rx_in_error <= 1'b1;
		rx_in_data <= 8'ha5;
		@(posedge pclk);
		rx_in_valid <= 1'b0;
		repeat (8)
		begin
			@(posedge pclk);
			if (rx_out_valid === 1'b1)
			begin
				q.push_back(rx_out_data);
				f.push_back({rx_out_sop, rx_out_last});
			end
			if (rx_frame_discard === 1'b1)
				disc++;
		end
		chk("rx_len", 32'(n) + 1, 32'(q.size()));
		for (int i = 0; i < q.size(); i++)
		begin
			chk("rx_byte", (i == n) ? 32'ha5 : 32'h0, q[i]);
			chk("rx_flags", {30'h0, i == 0, i == n}, f[i]);
		end
		chk("rx_drop", drop, disc);
	endtask : t_rx

	task automatic t_stall;
		wr(HW_CFG_OFF, 32'h0);
		tx_loss_of_sync <= 1'b1;
		@(posedge pclk);
		tx_loss_of_sync <= 1'b0;
		step(2);
		chk("stall_on", 1, bulk_out_stall);
		bulk_out_stall_clear <= 1'b1;
		@(posedge pclk);
		bulk_out_stall_clear <= 1'b0;
		wr(HW_CFG_OFF, 32'h100);
		tx_loss_of_sync <= 1'b1;
		@(posedge pclk);
		tx_loss_of_sync <= 1'b0;
		step(2);
		chk("stall_dis", 0, bulk_out_stall);
	endtask : t_stall

	// Full reset with an external PHY strapped
	task automatic t_full;
		int n;
		phy_choice_pin <= 1'b1;
		wr(HW_CFG_OFF, 32'h81);
		step(3);
		chk("ext_rst", 1, ext_phy_reset);
		chk("disc", 1, usb_phy_disconnect);
		wait_lvl(eeprom_reload, 1'b1, 60, n);
		chk("reload", 1, eeprom_reload);
		rdc("full_busy", HW_CFG_OFF, 32'h1, 32'h1);
		eeprom_load_done <= 1'b1;
		@(posedge pclk);
		eeprom_load_done <= 1'b0;
		step(2);
		chk("reconnect", 0, usb_phy_disconnect);
		rdc("full_ok", HW_CFG_OFF, 32'h6005, 32'h4004);
		wr(HW_CFG_OFF, 32'h80);
		step(2);
		chk("mii_ext", 0, mii_pins_drive);
	endtask : t_full

	task automatic t_lite;
		int n;
		wr(HW_CFG_OFF, 32'h2000);
		wr(HW_CFG_OFF, 32'h2008);
		step(2);
		chk("lite_dp", 1, datapath_reset);
		chk("lite_core", 0, usb_core_reset);
		chk("lite_conn", 0, usb_phy_disconnect);
		rdc("lite_busy", HW_CFG_OFF, 32'h8, 32'h8);
		wait_lvl(datapath_reset, 1'b0, 40, n);
		rdc("lite_done", HW_CFG_OFF, 32'h8, 32'h0);
		chk("lite_boost", 2'b10, hs_drive_boost);
		wr(HW_CFG_OFF, 32'h6000);
		usb_bus_reset <= 1'b1;
		@(posedge pclk);
		usb_bus_reset <= 1'b0;
		step(2);
		chk("usb_boost", 2'b10, hs_drive_boost);
	endtask : t_lite

	task automatic t_ee;
		int n;
		wr(HW_CFG_OFF, 32'h10);
		eeprom_busy <= 1'b1;
		wait_lvl(eeprom_timeout, 1'b1, 400, n);
		chk("ee_short", 1, 32'(n >= 126 && n <= 130));
		eeprom_busy <= 1'b0;
		wr(HW_CFG_OFF, 32'h0);
		eeprom_busy <= 1'b1;
		wait_lvl(eeprom_timeout, 1'b1, 400, n);
		chk("ee_long", 1, 32'(n >= EE_LONG - 2 && n <= EE_LONG + 2));
		eeprom_busy <= 1'b0;
		// An answered access must never time out
		@(posedge pclk);
		eeprom_response <= 1'b1;
		eeprom_busy <= 1'b1;
		wait_lvl(eeprom_timeout, 1'b1, 300, n);
		chk("ee_answered", 300, n);
		eeprom_busy <= 1'b0;
		eeprom_response <= 1'b0;
	endtask : t_ee

	// Unmapped access, then detach status set and clear
	task automatic t_misc;
		apb(1'b0, 12'h008, 32'h0);
		chk("unmapped_err", 1, err);
		chk("unmapped_data", 0, rd);
		detach_event <= 1'b1;
		@(posedge pclk);
		detach_event <= 1'b0;
		rdc("detach_set", HW_STATUS_OFF, 32'h1, 32'h1);
		wr(HW_STATUS_OFF, 32'h1);
		rdc("detach_clr", HW_STATUS_OFF, 32'h1, 32'h0);
	endtask : t_misc

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		phy_choice_pin = 1'b0;
		usb_bus_reset = 1'b0;
		detach_event = 1'b0;
		rx_datapath_enable = 1'b0;
		eeprom_present = 1'b1;
		eeprom_boost = 2'b10;
		eeprom_load_done = 1'b0;
		eeprom_busy = 1'b0;
		eeprom_response = 1'b0;
		tx_loss_of_sync = 1'b0;
		bulk_out_stall_clear = 1'b0;
		burst_limit_value = 16'h0123;
		rx_in_valid = 1'b0;
		rx_in_sop = 1'b0;
		rx_in_last = 1'b0;
		rx_in_error = 1'b0;
		rx_in_data = 8'h00;
		n_mismatch = 0;
		tests_run = 0;
		step(3);
		presetn <= 1'b1;
		t_fields();
		for (int i = 0; i < 4; i++)
			t_rx(2'(i), i[0]);
		t_stall();
		t_full();
		t_lite();
		t_ee();
		t_misc();
		final_report();
	end

	// Watchdog well beyond the expected run
	initial
	begin
		#200000;
		n_mismatch++;
		final_report();
	end
endmodule : testbench
